// ===== rtl/isc_ctrl.v
/*
 two-wire slave controller with apb register access and interrupt.
 assumes scl and sda arrive asynchronously and are open drain; sda is
 driven low when sda_oe_n is low. no clock stretching is done.
*/
// Our own choice: the APB register port.
`timescale 1ns/100ps
`include "isc_defs.vh"

module isc_ctrl (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        scl_in,
   input  wire        sda_in,
   output wire        sda_out,
   output wire        sda_oe_n,
   output wire        irq
);

   localparam [2:0] S_IDLE  = 3'd0;
   localparam [2:0] S_ADDR  = 3'd1;
   localparam [2:0] S_ACKA  = 3'd2;
   localparam [2:0] S_RX    = 3'd3;
   localparam [2:0] S_ACKR  = 3'd4;
   localparam [2:0] S_TX    = 3'd5;
   localparam [2:0] S_TXACK = 3'd6;

   function addr_hit;
      input [6:0] rx;
      input [6:0] own;
      input       dbl;
      begin
         addr_hit = dbl ? (rx[6:1] == own[6:1]) : (rx == own);
      end
   endfunction

   reg  [1:0] scl_s_q;
   reg  [1:0] sda_s_q;
   reg        scl_p_q;
   reg        sda_p_q;
   reg  [2:0] state_q;
   reg  [3:0] bitcnt_q;
   reg  [7:0] shreg_q;
   reg  [7:0] tx_sh_q;
   reg        got_nack_q;
   reg        want_q;
   reg        pend_q;
   reg  [4:0] hcnt_q;
   reg        drive_q;
   reg        slave_en_q;
   reg  [6:0] primary_slave_address_q;
   reg        second_match_enable_q;
   reg  [6:0] second_slave_address_q;
   reg  [6:0] received_address_q;
   reg        transmit_direction_q;
   reg        double_address_q;
   reg  [3:0] sda_hold_setting_q;
   reg  [7:0] rx_data_q;
   reg  [7:0] tx_data_q;
   reg        rx_buffer_flag_q;
   reg        tx_buffer_flag_q;
   reg        first_q;
   reg        addrm_q;
   reg        stop_q;
   reg        rpstart_q;
   reg        start_q;
   reg        nack_q;
   reg  [6:0] irq_stat_q;
   reg  [6:0] irq_mask_q;
   reg  [31:0] prdata_q;
   reg  [7:0] rd_mux;
   reg        mapped;

   wire scl       = scl_s_q[1];
   wire sda       = sda_s_q[1];
   wire scl_rise  = scl & ~scl_p_q;
   wire scl_fall  = ~scl & scl_p_q;
   wire start_det = scl & scl_p_q & sda_p_q & ~sda;
   wire stop_det  = scl & scl_p_q & ~sda_p_q & sda;

   wire [9:0] idx   = paddr[11:2];
   wire       setup = psel & ~penable;
   wire       acc   = psel & penable;
   wire       wr    = acc & pwrite;
   wire       rd    = acc & ~pwrite;
   wire       wr_st = wr & (idx == `ISC_IDX_STATUS);
   wire       wr_dt = wr & (idx == `ISC_IDX_DATA);
   wire       rd_dt = rd & (idx == `ISC_IDX_DATA);
   wire       rd_ir = rd & (idx == `ISC_IDX_IRQ_STAT);

   // event pulses from the bus engine
   wire ev_match = scl_fall & (state_q == S_ADDR) & (bitcnt_q == 4'd8) &
                   slave_en_q &
                   ((addr_hit(shreg_q[7:1], primary_slave_address_q, double_address_q)) |
                    (second_match_enable_q &
                     addr_hit(shreg_q[7:1], second_slave_address_q, double_address_q))); // R9 R14
   wire ev_rxbyte = scl_fall & (state_q == S_RX) & (bitcnt_q == 4'd8);
   wire ev_txload = scl_fall & (((state_q == S_ACKA) & transmit_direction_q) |
                    ((state_q == S_TXACK) & ~got_nack_q));
   wire ev_nack   = scl_rise & (state_q == S_TXACK) & sda;
   wire ev_rpst   = start_det & (state_q != S_IDLE);
   wire [6:0] ev_vec = {ev_match, stop_det, ev_rpst, ev_txload, ev_rxbyte, start_det, ev_nack};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_s_q <= 2'b11;
         sda_s_q <= 2'b11;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_s_q <= {sda_s_q[0], sda_in};
         scl_p_q <= scl;
         sda_p_q <= sda;
      end
   end

   // bus engine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= S_IDLE;
         bitcnt_q   <= 4'd0;
         shreg_q    <= `ISC_RESET_BYTE;
         tx_sh_q    <= `ISC_RESET_BYTE;
         got_nack_q <= 1'b0;
         want_q     <= 1'b0;
         pend_q     <= 1'b0;
         hcnt_q     <= 5'd0;
         drive_q    <= 1'b0;
         received_address_q   <= 7'h00;
         transmit_direction_q <= 1'b0;
      end else if (!slave_en_q || stop_det) begin
         state_q <= S_IDLE;
         drive_q <= 1'b0;
         pend_q  <= 1'b0;
      end else if (start_det) begin
         state_q  <= S_ADDR;
         bitcnt_q <= 4'd0;
         drive_q  <= 1'b0;
         pend_q   <= 1'b0;
      end else begin
         if (pend_q && hcnt_q == 5'd0) begin
            drive_q <= want_q;
            pend_q  <= 1'b0;
         end else if (hcnt_q != 5'd0) begin
            hcnt_q <= hcnt_q - 5'd1;
         end
         if (scl_rise) begin
            if (state_q == S_ADDR || state_q == S_RX) begin
               shreg_q  <= {shreg_q[6:0], sda};
               bitcnt_q <= bitcnt_q + 4'd1;
            end
            if (state_q == S_TXACK)
               got_nack_q <= sda;
         end
         if (scl_fall && state_q != S_IDLE) begin
            // new sda level waits hold setting plus base plus one clocks
            pend_q <= 1'b1;
            hcnt_q <= {1'b0, sda_hold_setting_q} + `ISC_HOLD_BASE;
            want_q <= 1'b0;
            case (state_q)
               S_ADDR: begin
                  if (bitcnt_q == 4'd8) begin
                     if (ev_match) begin
                        state_q <= S_ACKA;
                        want_q  <= 1'b1;
                        received_address_q   <= shreg_q[7:1];
                        transmit_direction_q <= shreg_q[0];
                     end else begin
                        state_q <= S_IDLE;
                     end
                  end
               end
               S_ACKA: begin
                  bitcnt_q <= 4'd0;
                  if (transmit_direction_q) begin
                     state_q <= S_TX;
                     tx_sh_q <= tx_data_q; // R8
                     want_q  <= ~tx_data_q[7];
                  end else begin
                     state_q <= S_RX;
                  end
               end
               S_RX: begin
                  if (bitcnt_q == 4'd8) begin
                     state_q <= S_ACKR;
                     want_q  <= 1'b1;
                  end
               end
               S_ACKR: begin
                  state_q  <= S_RX;
                  bitcnt_q <= 4'd0;
               end
               S_TX: begin
                  if (bitcnt_q == 4'd7) begin
                     state_q <= S_TXACK;
                  end else begin
                     bitcnt_q <= bitcnt_q + 4'd1;
                     tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
                     want_q   <= ~tx_sh_q[6];
                  end
               end
               S_TXACK: begin
                  bitcnt_q <= 4'd0;
                  if (got_nack_q) begin
                     state_q <= S_IDLE; // R5
                  end else begin
                     state_q <= S_TX;
                     tx_sh_q <= tx_data_q; // R8
                     want_q  <= ~tx_data_q[7];
                  end
               end
               default: state_q <= S_IDLE;
            endcase
         end
      end
   end

   // registers and flags; a hardware set wins over any clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slave_en_q              <= 1'b0;
         primary_slave_address_q <= 7'h00;
         second_match_enable_q   <= 1'b0;
         second_slave_address_q  <= 7'h00;
         double_address_q        <= 1'b0;
         sda_hold_setting_q      <= 4'h0;
         rx_data_q               <= `ISC_RESET_BYTE;
         tx_data_q               <= `ISC_RESET_BYTE;
         rx_buffer_flag_q        <= 1'b0;
         tx_buffer_flag_q        <= 1'b0;
         first_q                 <= 1'b0;
         addrm_q                 <= 1'b0;
         stop_q                  <= 1'b0;
         rpstart_q               <= 1'b0;
         start_q                 <= 1'b0;
         nack_q                  <= 1'b0;
         irq_stat_q              <= `ISC_RESET_IRQ;
         irq_mask_q              <= `ISC_RESET_IRQ;
      end else begin
         if (wr && idx == `ISC_IDX_ADDR1) begin
            slave_en_q              <= pwdata[`ISC_EN_BIT]; // R12
            primary_slave_address_q <= pwdata[6:0]; // R12
         end
         if (wr && idx == `ISC_IDX_ADDR2) begin
            second_match_enable_q  <= pwdata[`ISC_EN_BIT]; // R9
            second_slave_address_q <= pwdata[6:0]; // R10
         end
         if (wr && idx == `ISC_IDX_IRQ_MASK)
            irq_mask_q <= pwdata[6:0];
         if (wr_st) begin
            double_address_q   <= pwdata[`ISC_ST_DBL_ADDR]; // R14
            sda_hold_setting_q <= pwdata[3:0];
         end
         if (wr_dt)
            tx_data_q <= pwdata[7:0]; // R8
         if (ev_rxbyte)
            rx_data_q <= shreg_q; // R7
         // rx buffer flag and first-byte marker
         if (ev_rxbyte)
            rx_buffer_flag_q <= 1'b1; // R1
         else if (rd_dt)
            rx_buffer_flag_q <= 1'b0; // R1
         if (ev_rxbyte && (first_q || addrm_q))
            first_q <= 1'b1;
         else if (ev_match)
            first_q <= 1'b0;
         else if (rd_dt)
            first_q <= 1'b0;
         if (ev_txload)
            tx_buffer_flag_q <= 1'b1; // R13
         else if (wr_dt)
            tx_buffer_flag_q <= 1'b0; // R13
         // software clears addrm, stop and rpstart by writing zero
         if (ev_match)
            addrm_q <= 1'b1;
         else if (wr_st && !pwdata[`ISC_ST_ADDRM])
            addrm_q <= 1'b0;
         if (stop_det)
            stop_q <= 1'b1;
         else if (wr_st && !pwdata[`ISC_ST_STOP])
            stop_q <= 1'b0;
         if (ev_rpst)
            rpstart_q <= 1'b1;
         else if (wr_st && !pwdata[`ISC_ST_RPSTART])
            rpstart_q <= 1'b0;
         if (start_det)
            start_q <= 1'b1; // R2
         else if (stop_det)
            start_q <= 1'b0; // R3
         if (ev_nack)
            nack_q <= 1'b1; // R4
         else if (ev_match)
            nack_q <= 1'b0;
         irq_stat_q <= ev_vec | (irq_stat_q & ~(rd_ir ? prdata_q[6:0] : 7'h00));
      end
   end

   always @* begin
      mapped = 1'b1;
      case (idx)
         `ISC_IDX_STATUS:
            rd_mux = {first_q, addrm_q, stop_q, rpstart_q, tx_buffer_flag_q,
                      rx_buffer_flag_q, start_q, nack_q};
         `ISC_IDX_ADDR1:    rd_mux = {transmit_direction_q, received_address_q}; // R11
         `ISC_IDX_DATA:     rd_mux = rx_data_q; // R7
         `ISC_IDX_ADDR2:    rd_mux = {second_match_enable_q, 7'h00};
         `ISC_IDX_IRQ_STAT: rd_mux = {1'b0, irq_stat_q};
         `ISC_IDX_IRQ_MASK: rd_mux = {1'b0, irq_mask_q};
         default: begin
            rd_mux = 8'h00;
            mapped = 1'b0;
         end
      endcase
   end

   // read data is captured in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_q <= 32'h00000000;
      else if (setup && !pwrite)
         prdata_q <= {24'h000000, rd_mux};
   end

   assign prdata   = prdata_q;
   assign pready   = 1'b1;
   assign pslverr  = acc & ~mapped;
   assign sda_out  = 1'b0;
   assign sda_oe_n = ~drive_q;
   assign irq      = |(irq_stat_q & irq_mask_q);

endmodule

// ===== inc/isc_defs.vh
/*
 constants of the two-wire slave controller: register indices, field
 positions, reset values and timing counts.
 assumes an apb bus of 32-bit words, each register on an aligned word.
*/
// How it works
// [R1] rx buffer flag sets when a received byte lands; software read of data clears it
// [R2] start flag sets on every start condition seen on the bus lines
// [R3] start flag clears when a stop condition is seen
// [R4] nack flag sets when master answers a transmitted byte with nack
// [R5] after a master nack no further transmit byte is loaded into the shifter
// [R6] software keeps hold setting plus 3 clock periods at or above 300 ns; the bench sets 0 with a 10 ns clock, giving 30 ns
// [R7] reading the data register returns the last byte received from the bus
// [R8] writing the data register supplies the next byte to transmit
// [R9] second address also matches while its enable bit 7 is set
// [R10] second address register bits 6..0 hold the second seven-bit address
// [R11] primary address read: bit 7 direction, bits 6..0 last received address
// [R12] primary address write: bit 7 enables slave, bits 6..0 primary address
// [R13] tx buffer flag sets when a byte can be taken, clears on data write
// [R14] double address mode ignores the address lsb so two addresses match
`ifndef ISC_DEFS_VH
`define ISC_DEFS_VH

// register indices; byte address is four times the index
`define ISC_IDX_STATUS    10'h0dc
`define ISC_IDX_ADDR1     10'h0dd
`define ISC_IDX_DATA      10'h0de
`define ISC_IDX_ADDR2     10'h0df
`define ISC_IDX_IRQ_STAT  10'h0e0
`define ISC_IDX_IRQ_MASK  10'h0e1

// status register bits, then the address register enable bit
`define ISC_ST_FIRST      7
`define ISC_ST_DBL_ADDR   7
`define ISC_ST_ADDRM      6
`define ISC_ST_STOP       5
`define ISC_ST_RPSTART    4
`define ISC_ST_TXB        3
`define ISC_ST_RCB        2
`define ISC_ST_START      1
`define ISC_ST_NACK       0
`define ISC_EN_BIT        7

`define ISC_RESET_BYTE    8'h00
`define ISC_RESET_IRQ     7'h00

// hold delay is setting plus this many clocks plus one
`define ISC_HOLD_BASE     5'd3
`define ISC_HOLD_MIN_NS   300

`endif

// ===== sim/isc_ctrl_monitor.sv
/*
 port checker for the two-wire slave controller.
 assumes it is bound to isc_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
`include "isc_defs.vh"

module isc_ctrl_monitor (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        scl_in,
   input wire        sda_in,
   input wire        sda_out,
   input wire        sda_oe_n,
   input wire        irq
);
   wire [9:0] idx    = paddr[11:2];
   wire       acc    = psel && penable;
   wire       mapped = idx >= `ISC_IDX_STATUS && idx <= `ISC_IDX_IRQ_MASK;
   wire       rd_st  = acc && !pwrite && idx == `ISC_IDX_STATUS;
   wire       rd_dt  = acc && !pwrite && idx == `ISC_IDX_DATA;
   wire       wr_dt  = acc && pwrite && idx == `ISC_IDX_DATA;
   wire       wr_a1  = acc && pwrite && idx == `ISC_IDX_ADDR1;
   wire       wr_msk = acc && pwrite && idx == `ISC_IDX_IRQ_MASK;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_zero_wait: assert property (psel && !penable |=> pready)
      else $error("access phase not ready");
   a_err_unmapped: assert property (acc && !mapped |-> pslverr)
      else $error("no error on unmapped index");
   a_err_mapped: assert property (acc && mapped |-> !pslverr)
      else $error("error on mapped index");
   a_rx_flag_clear: assert property (rd_dt ##[2:3] rd_st |-> !prdata[`ISC_ST_RCB])
      else $error("rx flag kept after data read");
   a_tx_flag_clear: assert property (wr_dt ##[2:3] rd_st |-> !prdata[`ISC_ST_TXB])
      else $error("tx flag kept after data write");
   a_disable_quiet: assert property (wr_a1 && !pwdata[7] |-> ##2 sda_oe_n [*6])
      else $error("line driven while disabled");
   a_irq_masked: assert property (wr_msk && pwdata[6:0] == 7'h00 |=> !irq)
      else $error("irq high with all masked");
   a_open_drain: assert property (sda_out == 1'b0)
      else $error("data line driven high");
endmodule

bind isc_ctrl isc_ctrl_monitor u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));

// ===== sim/isc_i2c_master.sv
/*
 behavioural two-wire bus master driving clock and data.
 assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/100ps

module isc_i2c_master (
   output reg  scl,
   output reg  sda_m,
   input  wire sda
);
   initial begin
      scl = 1;
      sda_m = 1;
   end

   // clock stands high between frames
   task start;
      begin
         sda_m = 0;
         #80 scl = 0;
      end
   endtask

   task stop;
      begin
         #20 sda_m = 0;
         #60 scl = 1;
         #80 sda_m = 1;
         #80;
      end
   endtask

   task restart;
      begin
         #20 sda_m = 1;
         #60 scl = 1;
         #80 sda_m = 0;
         #80 scl = 0;
      end
   endtask

   // low 80 ns then high 80 ns; slave answers late in low phase
   task bit_io(input b, output r);
      begin
         #20 sda_m = b;
         #60 scl = 1;
         #79 r = sda;
         #1 scl = 0;
      end
   endtask

   task xfer(input [7:0] d, input ack_in, output [7:0] q, output ack);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_io(d[i], q[i]);
         end
         bit_io(ack_in, ack);
      end
   endtask
endmodule

// ===== sim/isc_ctrl_bench.sv
/*
 self-checking bench for the two-wire slave controller.
 assumes apb access with zero wait states and a bus master model.
*/
`timescale 1ns/100ps
`include "isc_defs.vh"

module isc_ctrl_bench;
   localparam [9:0] ist = `ISC_IDX_STATUS;
   localparam [9:0] ia1 = `ISC_IDX_ADDR1;
   localparam [9:0] idt = `ISC_IDX_DATA;
   localparam [9:0] ia2 = `ISC_IDX_ADDR2;
   localparam [9:0] iis = `ISC_IDX_IRQ_STAT;
   localparam [9:0] iim = `ISC_IDX_IRQ_MASK;
   // hold field; the 80 ns link low phase leaves room for zero only
   localparam [3:0] hold_set = 4'h0;
   reg         pclk, presetn, psel, penable, pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   wire [31:0] prdata;
   wire        pready, pslverr, sda_out, sda_oe_n, irq, scl, sda_m;
   wire        sda = sda_m & (sda_oe_n | sda_out);
   integer     mismatches, check_count, i;
   reg  [7:0]  rv, q;
   reg         ev, a;

   isc_ctrl DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
   isc_i2c_master m (.scl(scl), .sda_m(sda_m), .sda(sda));

   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end

   task end_sim;
      begin
         if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask

   task cmp8(input [7:0] g, input [7:0] e);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("BAD %0t got %h exp %h", $time, g, e);
         end
      end
   endtask

   task cmpb(input g, input e);
      begin
         cmp8({7'h00, g}, {7'h00, e});
      end
   endtask

   task apb(input w, input [9:0] x, input [7:0] d);
      begin
         @(posedge pclk);
         psel <= 1;
         penable <= 0;
         pwrite <= w;
         paddr <= {x, 2'b00};
         pwdata <= {24'h0, d};
         @(posedge pclk);
         penable <= 1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rv = prdata[7:0];
         ev = pslverr;
         psel <= 0;
         penable <= 0;
      end
   endtask

   task rd(input [9:0] x);
      begin
         apb(0, x, 8'h00);
      end
   endtask

   task wr(input [9:0] x, input [7:0] d);
      begin
         apb(1, x, d);
      end
   endtask

   initial begin
      #200000;
      mismatches = mismatches + 1;
      end_sim;
   end

   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      presetn = 0; mismatches = 0; check_count = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      for (i = 0; i < 6; i = i + 1) begin
         rd(ist + i[9:0]);
         cmp8(rv, 8'h00);
         cmpb(ev, 0);
      end
      rd(10'h0f0);
      cmpb(ev, 1);
      wr(iim, 8'h7f);
      wr(ia1, 8'haa);
      wr(ia2, 8'hb3);
      rd(ia2); cmp8(rv, 8'h80);
      m.start; rd(ist); cmpb(rv[1], 1);
      m.xfer(8'h54, 1, q, a); cmpb(a, 0);
      m.xfer(8'h5a, 1, q, a); cmpb(a, 0);
      rd(ist); cmpb(rv[2], 1);
      rd(ia1); cmp8(rv, 8'h2a);
      @(negedge pclk) cmpb(irq, 1);
      wr(iim, 8'h00);
      @(negedge pclk) cmpb(irq, 0);
      wr(iim, 8'h7f);
      rd(iis); cmp8(rv, 8'h46);
      @(negedge pclk) cmpb(irq, 0);
      rd(idt); cmp8(rv, 8'h5a);
      rd(ist); cmpb(rv[2], 0);
      m.restart; rd(ist); cmp8(rv & 8'h30, 8'h10);
      m.stop; rd(ist); cmpb(rv[1], 0);
      cmpb(rv[5], 1);
      // second address on, off, mismatch, then double address
      for (i = 0; i < 4; i = i + 1) begin
         wr(ist, {i == 3, 3'h0, hold_set});
         wr(ia2, {i != 1, 7'h33});
         m.start;
         m.xfer(i == 3 ? 8'h56 : i == 2 ? 8'h68 : 8'h66, 1, q, a);
         cmpb(a, i == 1 || i == 2);
         m.stop;
      end
      wr(ist, 8'h00);
      wr(ia1, 8'h2a);
      m.start; m.xfer(8'h54, 1, q, a); cmpb(a, 1);
      m.stop;
      wr(ia1, 8'haa);
      wr(idt, 8'ha5); rd(ist); cmpb(rv[3], 0);
      m.start; m.xfer(8'h55, 1, q, a); cmpb(a, 0);
      // tx load lands on the synced fall; its first bit drives hold+3+1 clocks later
      repeat (10) @(posedge pclk);
      rd(ist); cmpb(rv[3], 1);
      wr(idt, 8'ha5); rd(ist); cmpb(rv[3], 0);
      rd(ia1); cmp8(rv, 8'haa);
      m.xfer(8'hff, 1, q, a); cmp8(q, 8'ha5);
      rd(ist); cmpb(rv[0], 1);
      m.xfer(8'hff, 1, q, a); cmp8(q, 8'hff);
      m.stop;
      end_sim;
   end
endmodule
